// ===== serial_bridge.sv
// serial bridge between a target uart and the relay side, apb register access
// assumes target pins are asynchronous and flow lines active low; one 40 MHz clock
`timescale 1ns/1ps
`include "bridge_defines.svh"
module serial_bridge #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEFAULT
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // bridge enable
  input wire logic enable_in,
  // target serial pins
  input wire logic target_tx_in,
  output logic target_rx_out,
  // flow control, active low; cts has an output enable (low = driven)
  output logic cts_n_out,
  output logic cts_oe_n_out,
  input wire logic rts_n_in
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  initial begin
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 64) begin
      $error("serial_bridge: fifo depth out of range");
    end
  end

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // clamp a requested divider into the legal baud range
  function automatic logic [15:0] clamp_div(input logic [31:0] d);
    if (d < `DIV_MIN) begin
      clamp_div = 16'(`DIV_MIN);
    end else if (d > `DIV_MAX) begin
      clamp_div = 16'(`DIV_MAX);
    end else begin
      clamp_div = d[15:0];
    end
  endfunction

  // ----------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------
  logic rst_s1_reg; // first reset release flop
  logic rst_reg; // synchronous reset, active high
  logic [1:0] tx_sync_reg; // target tx line
  logic [1:0] rts_sync_reg; // target rts line, active low
  logic [1:0] en_sync_reg; // bridge enable
  logic tx_line;
  logic rts_ready;
  logic enabled;

  // reset asserts at once, releases after two edges
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_s1_reg <= 1'b1;
      rst_reg <= 1'b1;
    end else begin
      rst_s1_reg <= 1'b0;
      rst_reg <= rst_s1_reg;
    end
  end

  // two flops on each asynchronous pin; idle levels at reset
  always_ff @(posedge clk_in) begin
    if (rst_reg) begin
      tx_sync_reg <= 2'h3;
      rts_sync_reg <= 2'h3;
      en_sync_reg <= 2'h0;
    end else begin
      tx_sync_reg <= {tx_sync_reg[0], target_tx_in};
      rts_sync_reg <= {rts_sync_reg[0], rts_n_in};
      en_sync_reg <= {en_sync_reg[0], enable_in};
    end
  end

  assign tx_line = tx_sync_reg[1];
  assign rts_ready = !rts_sync_reg[1]; // low means ready
  assign enabled = en_sync_reg[1];

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  bridge_pkg::apb_req_t req;
  bridge_pkg::hs_mode_t hs_mode_reg; // handshake mode
  logic [15:0] div_reg; // clocks per bit
  logic wr_acc;
  logic rd_acc;
  logic gate_tx;
  logic throttle_rx;

  assign req = '{sel: psel_in, enable: penable_in, write: pwrite_in, addr: paddr_in, wdata: pwdata_in};
  assign wr_acc = req.sel && req.enable && req.write;
  assign rd_acc = req.sel && req.enable && !req.write;

  // mode decode: cts mode bit gates tx, rts mode bit throttles rx
  assign gate_tx = (hs_mode_reg == bridge_pkg::HS_CTS) || (hs_mode_reg == bridge_pkg::HS_RTSCTS);
  assign throttle_rx = (hs_mode_reg == bridge_pkg::HS_RTS) || (hs_mode_reg == bridge_pkg::HS_RTSCTS);

  // software writes to control and baud
  always_ff @(posedge clk_in) begin
    if (rst_reg) begin
      hs_mode_reg <= bridge_pkg::hs_mode_t'(`CTRL_RESET);
      div_reg <= 16'(`DIV_DEFAULT);
    end else if (wr_acc) begin
      if (req.addr == `OFS_CTRL) begin
        hs_mode_reg <= bridge_pkg::hs_mode_t'(req.wdata[`CTRL_HS_MSB:`CTRL_HS_LSB]);
      end
      if (req.addr == `OFS_BAUD) begin
        div_reg <= clamp_div(req.wdata);
      end
    end
  end

  // ----------------------------------------
  // fifos: relay-to-target and target-to-relay
  // ----------------------------------------
  logic txf_in_valid;
  logic txf_in_ready;
  logic txf_out_valid;
  logic txf_out_ready;
  logic [7:0] txf_out_data;
  logic rxf_in_valid;
  logic rxf_in_ready;
  logic rxf_out_valid;
  logic rxf_out_ready;
  logic [7:0] rxf_out_data;
  logic [7:0] rx_byte_reg;

  // a write to the data register pushes a byte while enabled; a full fifo drops it (see status)
  assign txf_in_valid = wr_acc && (req.addr == `OFS_TXD) && enabled;
  // a read of the receive register pops one byte
  assign rxf_out_ready = rd_acc && (req.addr == `OFS_RXD);

  bridge_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .clk_in(clk_in),
    .rst_in(rst_reg),
    .in_valid_in(txf_in_valid),
    .in_ready_out(txf_in_ready),
    .in_data_in(req.wdata[7:0]),
    .out_valid_out(txf_out_valid),
    .out_ready_in(txf_out_ready),
    .out_data_out(txf_out_data)
  );

  bridge_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .clk_in(clk_in),
    .rst_in(rst_reg),
    .in_valid_in(rxf_in_valid),
    .in_ready_out(rxf_in_ready),
    .in_data_in(rx_byte_reg),
    .out_valid_out(rxf_out_valid),
    .out_ready_in(rxf_out_ready),
    .out_data_out(rxf_out_data)
  );

  // ----------------------------------------
  // transmitter toward the target
  // ----------------------------------------
  bridge_pkg::ser_state_t tx_state_reg;
  logic [15:0] tx_cnt_reg; // clocks left in this bit
  logic [2:0] tx_bit_reg; // data bit index
  logic [7:0] tx_shift_reg; // byte being sent
  logic tx_may_start;

  // a new character starts only if enabled and, when gating, rts is ready
  assign tx_may_start = enabled && txf_out_valid && (!gate_tx || rts_ready);
  assign txf_out_ready = (tx_state_reg == bridge_pkg::SER_IDLE) && tx_may_start;

  // framing: once started a character always runs to its stop bit
  always_ff @(posedge clk_in) begin
    if (rst_reg) begin
      tx_state_reg <= bridge_pkg::SER_IDLE;
      tx_cnt_reg <= '0;
      tx_bit_reg <= '0;
      tx_shift_reg <= '0;
      target_rx_out <= 1'b1;
    end else begin
      case (tx_state_reg)
        bridge_pkg::SER_IDLE: begin
          target_rx_out <= 1'b1; // idle high
          if (tx_may_start) begin
            tx_shift_reg <= txf_out_data;
            tx_cnt_reg <= div_reg - 16'h0001;
            target_rx_out <= 1'b0; // start bit
            tx_state_reg <= bridge_pkg::SER_START;
          end
        end
        bridge_pkg::SER_START: begin
          if (tx_cnt_reg == '0) begin
            tx_cnt_reg <= div_reg - 16'h0001;
            target_rx_out <= tx_shift_reg[0]; // lsb first
            tx_bit_reg <= '0;
            tx_state_reg <= bridge_pkg::SER_DATA;
          end else begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
          end
        end
        bridge_pkg::SER_DATA: begin
          if (tx_cnt_reg == '0) begin
            tx_cnt_reg <= div_reg - 16'h0001;
            if (tx_bit_reg == 3'h7) begin
              target_rx_out <= 1'b1; // stop bit
              tx_state_reg <= bridge_pkg::SER_STOP;
            end else begin
              target_rx_out <= tx_shift_reg[tx_bit_reg + 3'h1];
              tx_bit_reg <= tx_bit_reg + 3'h1;
            end
          end else begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
          end
        end
        bridge_pkg::SER_STOP: begin
          if (tx_cnt_reg == '0) begin
            tx_state_reg <= bridge_pkg::SER_IDLE;
          end else begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
          end
        end
        default: begin
          tx_state_reg <= bridge_pkg::SER_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // receiver from the target
  // ----------------------------------------
  bridge_pkg::ser_state_t rx_state_reg;
  logic [15:0] rx_cnt_reg; // clocks to next sample point
  logic [2:0] rx_bit_reg; // data bit index
  logic rx_push_reg; // one-cycle push into rx fifo
  logic rx_ferr_reg; // sticky framing error, cleared by status read

  assign rxf_in_valid = rx_push_reg;

  // samples mid-bit; characters only accepted while enabled
  always_ff @(posedge clk_in) begin
    if (rst_reg) begin
      rx_state_reg <= bridge_pkg::SER_IDLE;
      rx_cnt_reg <= '0;
      rx_bit_reg <= '0;
      rx_byte_reg <= '0;
      rx_push_reg <= 1'b0;
    end else begin
      rx_push_reg <= 1'b0;
      case (rx_state_reg)
        bridge_pkg::SER_IDLE: begin
          if (!tx_line && enabled) begin
            rx_cnt_reg <= {1'b0, div_reg[15:1]}; // half bit to centre
            rx_state_reg <= bridge_pkg::SER_START;
          end
        end
        bridge_pkg::SER_START: begin
          if (rx_cnt_reg == '0) begin
            // a glitch that is high mid-bit is not a start
            rx_state_reg <= tx_line ? bridge_pkg::SER_IDLE : bridge_pkg::SER_DATA;
            rx_cnt_reg <= div_reg - 16'h0001;
            rx_bit_reg <= '0;
          end else begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
          end
        end
        bridge_pkg::SER_DATA: begin
          if (rx_cnt_reg == '0) begin
            rx_byte_reg <= {tx_line, rx_byte_reg[7:1]}; // lsb first
            rx_cnt_reg <= div_reg - 16'h0001;
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == 3'h7) begin
              rx_state_reg <= bridge_pkg::SER_STOP;
            end
          end else begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
          end
        end
        bridge_pkg::SER_STOP: begin
          if (rx_cnt_reg == '0) begin
            // good stop bit: push; a full fifo drops it, as cts should have held the target
            rx_push_reg <= tx_line && rxf_in_ready && enabled;
            rx_state_reg <= bridge_pkg::SER_IDLE;
          end else begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
          end
        end
        default: begin
          rx_state_reg <= bridge_pkg::SER_IDLE;
        end
      endcase
    end
  end

  // framing error flag: hardware set wins over the clearing read
  always_ff @(posedge clk_in) begin
    if (rst_reg) begin
      rx_ferr_reg <= 1'b0;
    end else if (rx_state_reg == bridge_pkg::SER_STOP && rx_cnt_reg == '0 && !tx_line) begin
      rx_ferr_reg <= 1'b1;
    end else if (rd_acc && req.addr == `OFS_STAT) begin
      rx_ferr_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // clear-to-send toward the target
  // ----------------------------------------
  // driven only in rts and rtscts modes; high (not ready) once the rx fifo is full
  always_ff @(posedge clk_in) begin
    if (rst_reg) begin
      cts_n_out <= 1'b1;
      cts_oe_n_out <= 1'b1; // undriven after reset
    end else begin
      cts_oe_n_out <= !throttle_rx;
      cts_n_out <= !rxf_in_ready || !enabled;
    end
  end

  // ----------------------------------------
  // apb read data and response
  // ----------------------------------------
  logic [31:0] rdata;
  logic mapped;

  // read mux; unmapped addresses answer with pslverr
  always_comb begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    case (req.addr)
      `OFS_CTRL: rdata[`CTRL_HS_MSB:`CTRL_HS_LSB] = hs_mode_reg;
      `OFS_BAUD: rdata[15:0] = div_reg;
      `OFS_STAT: begin
        rdata[`STAT_TX_FULL] = !txf_in_ready;
        rdata[`STAT_RX_EMPTY] = !rxf_out_valid;
        rdata[`STAT_RX_FULL] = !rxf_in_ready;
        rdata[`STAT_TX_BUSY] = (tx_state_reg != bridge_pkg::SER_IDLE);
        rdata[`STAT_CTS_OE_N] = cts_oe_n_out;
        rdata[`STAT_RTS_SEEN] = rts_ready;
        rdata[`STAT_ENABLED] = enabled;
        rdata[`STAT_RX_FERR] = rx_ferr_reg;
      end
      `OFS_TXD: rdata = 32'h0000_0000;
      `OFS_RXD: rdata = {23'h000000, rxf_out_valid, rxf_out_data};
      default: mapped = 1'b0;
    endcase
  end

  // zero-wait response registered at the setup phase, so pready rises in the access cycle
  always_ff @(posedge clk_in) begin
    if (rst_reg) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else if (req.sel && !req.enable) begin
      pready_out <= 1'b1;
      pslverr_out <= !mapped;
      prdata_out <= req.write ? 32'h0000_0000 : rdata;
    end else begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

endmodule

// ===== bridge_defines.svh
// constants for the serial bridge: apb offsets, field positions, reset values, timing
// assumes a 40 MHz system clock and a 32-bit apb slave
`ifndef BRIDGE_DEFINES_SVH
`define BRIDGE_DEFINES_SVH

// ----------------------------------------
// clock and baud
// ----------------------------------------
`define CLK_HZ 40000000
`define BAUD_DEFAULT 115200
`define BAUD_MIN 9600
`define BAUD_MAX 921600
// divider = clk / baud, rounded down (longest bit time never overshoots)
`define DIV_DEFAULT (`CLK_HZ / `BAUD_DEFAULT)
`define DIV_MIN (`CLK_HZ / `BAUD_MAX)
`define DIV_MAX (`CLK_HZ / `BAUD_MIN)

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL 12'h000
`define OFS_BAUD 12'h004
`define OFS_STAT 12'h008
`define OFS_TXD 12'h00C
`define OFS_RXD 12'h010

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_HS_LSB 0
`define CTRL_HS_MSB 1
`define STAT_TX_FULL 0
`define STAT_RX_EMPTY 1
`define STAT_RX_FULL 2
`define STAT_TX_BUSY 3
`define STAT_CTS_OE_N 4
`define STAT_RTS_SEEN 5
`define STAT_ENABLED 6
`define STAT_RX_FERR 7
`define RXD_VALID 8

// ----------------------------------------
// reset values
// ----------------------------------------
`define CTRL_RESET 2'h0
`define FIFO_DEPTH_DEFAULT 4

`endif

// ===== bridge_pkg.sv
// types shared by the serial bridge files
// assumes bridge_defines.svh is seen by the modules, not by this package
package bridge_pkg;

  // handshake modes, encoding as written to the control register
  typedef enum logic [1:0] {
    HS_DISABLED = 2'h0,
    HS_RTS = 2'h1,
    HS_CTS = 2'h2,
    HS_RTSCTS = 2'h3
  } hs_mode_t;

  // serial engine states, gray along idle-start-data-stop
  typedef enum logic [1:0] {
    SER_IDLE = 2'h0,
    SER_START = 2'h1,
    SER_DATA = 2'h3,
    SER_STOP = 2'h2
  } ser_state_t;

  // apb request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

endpackage

// ===== bridge_fifo.sv
// small flop-based fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high clear derived from the system reset
`timescale 1ns/1ps
module bridge_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // depth must be a power of two so the pointers wrap for free
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("bridge_fifo: unsupported width or depth");
    end
  end

  logic [WIDTH-1:0] mem_reg [DEPTH]; // storage
  logic [AW-1:0] wr_ptr_reg; // next slot to fill
  logic [AW-1:0] rd_ptr_reg; // next slot to drain
  logic [AW:0] count_reg; // words held
  logic push;
  logic pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign in_ready_out = (count_reg != DEPTH[AW:0]);
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem_reg[rd_ptr_reg];

  // storage write; no reset needed, count guards reads
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// ===== serial_bridge_asserts.sv
// port checker for the serial bridge
// assumes a bind into serial_bridge; sees only its ports
`timescale 1ns/1ps
module serial_bridge_asserts #(
  parameter int FIFO_DEPTH = 4
) (
  // clock, reset and apb
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // bridge pins
  input wire logic enable_in,
  input wire logic target_tx_in,
  input wire logic target_rx_out,
  input wire logic cts_n_out,
  input wire logic cts_oe_n_out,
  input wire logic rts_n_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [1:0] mode_reg; // last handshake mode written
  logic [2:0] mode_age_reg; // cycles since that write, saturating
  logic [2:0] en_lo_reg; // cycles the enable has been low, saturating
  // ----------------------------------------
  // helpers: follow mode writes and enable level
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_reg <= 2'h0;
      mode_age_reg <= 3'h7;
    end else if (psel_in && penable_in && pwrite_in && pready_out && paddr_in == 12'h000) begin
      mode_reg <= pwdata_in[1:0];
      mode_age_reg <= 3'h0;
    end else if (mode_age_reg != 3'h7) begin
      mode_age_reg <= mode_age_reg + 3'h1;
    end
  end
  // enable is synced inside; allow a few cycles
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_lo_reg <= 3'h0;
    end else if (enable_in) begin
      en_lo_reg <= 3'h0;
    end else if (en_lo_reg != 3'h7) begin
      en_lo_reg <= en_lo_reg + 3'h1;
    end
  end
  // ----------------------------------------
  // apb phases
  // ----------------------------------------
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_answer;
    psel_in && penable_in && pready_out;
  endsequence
  a_setup_answer: assert property (s_setup |=> s_answer)
    else $error("no answer after setup");
  a_ready_single: assert property (pready_out |=> !pready_out)
    else $error("pready held too long");
  a_err_reads_zero: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("bad error response");
  a_mapped_no_err: assert property (pready_out && paddr_in <= 12'h010 && paddr_in[1:0] == 2'h0 |-> !pslverr_out)
    else $error("error on mapped register");
  // ----------------------------------------
  // pins
  // ----------------------------------------
  a_reset_idle_pins: assert property (@(posedge clk_in) disable iff (1'b0)
    !arst_n_in [*2] |-> target_rx_out && cts_n_out && cts_oe_n_out)
    else $error("pins not idle during reset");
  a_start_bit_hold: assert property ($fell(target_rx_out) |-> !target_rx_out [*8])
    else $error("low level too short");
  a_stop_bit_hold: assert property ($rose(target_rx_out) |-> target_rx_out [*8])
    else $error("high level too short");
  a_cts_undriven: assert property (mode_age_reg == 3'h7 && !mode_reg[0] |-> cts_oe_n_out)
    else $error("cts driven without throttle");
  a_cts_driven: assert property (mode_age_reg == 3'h7 && mode_reg[0] |-> !cts_oe_n_out)
    else $error("cts undriven in throttle");
  a_cts_disabled: assert property (en_lo_reg == 3'h7 && !cts_oe_n_out |-> cts_n_out)
    else $error("cts ready while disabled");
endmodule

bind serial_bridge serial_bridge_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.*);

// ===== target_uart.sv
// behavioural target uart with flow control, far side of the bridge
// assumes the bench sets div, stall and tx_q; received bytes land in got
`timescale 1ns/1ps
module target_uart (
  // clock
  input wire logic clk_in,
  // lines from the bridge
  input wire logic rx_in,
  input wire logic cts_n_in,
  input wire logic cts_oe_n_in,
  // lines to the bridge
  output logic tx_out = 1'b1,
  output logic rts_n_out = 1'b1
);
  int div = 43; // clocks per bit
  bit stall = 1'b0; // bench asks the target to hold off data
  logic [7:0] tx_q[$]; // bytes still to send
  logic [7:0] got[$]; // bytes received
  int ferr = 0; // bad stop bits seen
  logic [7:0] rb; // receive shift
  logic [9:0] fr; // outgoing frame
  // request-to-send low only while ready, changed after an edge
  always @(posedge clk_in) rts_n_out <= stall;
  // receiver: takes whole characters even after stall
  always begin
    @(negedge rx_in);
    repeat (div / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge clk_in);
      rb[i] = rx_in;
    end
    repeat (div) @(posedge clk_in);
    if (rx_in !== 1'b1) ferr++;
    got.push_back(rb);
  end
  // transmitter: driven high cts holds off new characters
  always begin
    @(posedge clk_in);
    if (tx_q.size() > 0 && (cts_oe_n_in || !cts_n_in)) begin
      fr = {1'b1, tx_q.pop_front(), 1'b0};
      for (int i = 0; i < 10; i++) begin
        tx_out <= fr[i];
        repeat (div) @(posedge clk_in);
      end
    end
  end
endmodule

// ===== test_serial_bridge.sv
// self-checking bench for the serial bridge with a target uart model
// assumes serial_bridge, its checker and target_uart are compiled first
`timescale 1ns/1ps
`include "bridge_defines.svh"
module test_serial_bridge;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic enable_in = 1'b1;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, target_tx_in, target_rx_out, cts_n_out, cts_oe_n_out, rts_n_in;
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 32'h11a3;
  logic [7:0] exp_tx[$]; // model: bytes due at the target
  logic [7:0] exp_rx[$]; // model: bytes due in the receive register
  always #12.5 clk_in = ~clk_in;
  serial_bridge #(.FIFO_DEPTH(4)) uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .enable_in(enable_in),
    .target_tx_in(target_tx_in), .target_rx_out(target_rx_out), .cts_n_out(cts_n_out),
    .cts_oe_n_out(cts_oe_n_out), .rts_n_in(rts_n_in));
  target_uart peer (.clk_in(clk_in), .rx_in(target_rx_out), .cts_n_in(cts_n_out),
    .cts_oe_n_in(cts_oe_n_out), .tx_out(target_tx_in), .rts_n_out(rts_n_in));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, then an idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    chk("pready", {31'h0, pready_out}, 32'h1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdc(input string w, input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(w, q & m, x);
  endtask
  task automatic wait_got(input int n);
    for (int k = 0; k < 20000 && peer.got.size() < n; k++) @(posedge clk_in);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog: the tests need about 10000 cycles
  initial begin
    #(25 * 60000);
    n_mismatch++;
    $display("watchdog expired");
    conclude();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    logic e;
    logic [7:0] b;
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    // reset values and an unmapped place
    rdc("ctrl reset", `OFS_CTRL, 32'h3, 32'h0);
    rdc("baud reset", `OFS_BAUD, 32'hFFFFFFFF, `CLK_HZ / 115200);
    apb(1'b0, 12'h014, 32'h0, q, e);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", q, 32'h0);
    // baud bounds are clamped
    wr(`OFS_BAUD, 32'h1);
    rdc("baud low", `OFS_BAUD, 32'hFFFFFFFF, `CLK_HZ / 921600);
    wr(`OFS_BAUD, 32'hFFFF);
    rdc("baud high", `OFS_BAUD, 32'hFFFFFFFF, `CLK_HZ / 9600);
    wr(`OFS_BAUD, `CLK_HZ / 921600);
    peer.div = `CLK_HZ / 921600;
    $display("test registers done");
    // every mode: clear-to-send drive
    for (int m = 0; m < 4; m++) begin
      wr(`OFS_CTRL, m);
      repeat (4) @(posedge clk_in);
      rdc("cts oe status", `OFS_STAT, 32'h10, m[0] ? 32'h0 : 32'h10);
    end
    $display("test modes done");
    // disabled mode ignores rts; sixth write overflows
    wr(`OFS_CTRL, bridge_pkg::HS_DISABLED);
    peer.stall = 1'b1;
    for (int i = 0; i < 6; i++) begin
      b = $random(seed);
      wr(`OFS_TXD, {24'h0, b});
      if (i < 5) exp_tx.push_back(b);
    end
    rdc("tx full", `OFS_STAT, 32'h1, 32'h1);
    wait_got(5);
    repeat (600) @(posedge clk_in);
    chk("tx count", peer.got.size(), 32'h5);
    while (peer.got.size() > 0) chk("tx byte", peer.got.pop_front(), exp_tx.pop_front());
    chk("tx frame", peer.ferr, 32'h0);
    $display("test transmit done");
    // gated mode: hold, release, re-hold mid character
    wr(`OFS_CTRL, bridge_pkg::HS_CTS);
    for (int i = 0; i < 2; i++) begin
      b = $random(seed);
      wr(`OFS_TXD, {24'h0, b});
      exp_tx.push_back(b);
    end
    repeat (600) @(posedge clk_in);
    chk("held count", peer.got.size(), 32'h0);
    peer.stall = 1'b0;
    for (int k = 0; k < 400 && target_rx_out !== 1'b0; k++) @(posedge clk_in);
    repeat (60) @(posedge clk_in);
    peer.stall = 1'b1;
    wait_got(1);
    repeat (600) @(posedge clk_in);
    chk("finished count", peer.got.size(), 32'h1);
    chk("finished byte", peer.got.pop_front(), exp_tx.pop_front());
    peer.stall = 1'b0;
    wait_got(1);
    chk("resumed byte", peer.got.pop_front(), exp_tx.pop_front());
    // throttle-only mode ignores rts
    wr(`OFS_CTRL, bridge_pkg::HS_RTS);
    peer.stall = 1'b1;
    b = $random(seed);
    wr(`OFS_TXD, {24'h0, b});
    wait_got(1);
    chk("ignored hold byte", peer.got.pop_front(), b);
    $display("test gating done");
    // combined mode: target overfills rx
    wr(`OFS_CTRL, bridge_pkg::HS_RTSCTS);
    for (int i = 0; i < 6; i++) begin
      b = $random(seed);
      peer.tx_q.push_back(b);
      exp_rx.push_back(b);
    end
    repeat (3000) @(posedge clk_in);
    chk("cts when full", {31'h0, cts_n_out}, 32'h1);
    chk("target held", peer.tx_q.size(), 32'h2);
    rdc("rx full", `OFS_STAT, 32'h4, 32'h4);
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 400; k++) begin
        apb(1'b0, `OFS_RXD, 32'h0, q, e);
        if (q[`RXD_VALID] === 1'b1) break;
      end
      chk("rx byte", q[8:0], {1'b1, exp_rx.pop_front()});
    end
    $display("test receive done");
    // bridge disabled: nothing passes, target throttled
    enable_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk("cts disabled", {31'h0, cts_n_out}, 32'h1);
    wr(`OFS_TXD, 32'hA5);
    repeat (1000) @(posedge clk_in);
    chk("disabled tx", peer.got.size(), 32'h0);
    rdc("disabled rx empty", `OFS_STAT, 32'h2, 32'h2);
    $display("test enable done");
    conclude();
  end
endmodule
